//--- verilog/otl_pkg.sv
// Package with constants and types for the output terminal trip logic
package otl_pkg;
	// Function selector codes
	localparam logic [7:0] OTL_FN_FDT       = 8'h01;
	localparam logic [7:0] OTL_FN_RUN       = 8'h0e;
	localparam logic [7:0] OTL_FN_TRIP      = 8'h1c;
	localparam logic [7:0] OTL_FN_ENC_DIR   = 8'h21;
	localparam logic [7:0] OTL_FN_EBUF      = 8'h24;
	localparam logic [7:0] OTL_FN_FIRE      = 8'h25;
	localparam logic [7:0] OTL_FN_XRUN      = 8'h26;
	// Trip mask field positions and reset value
	localparam int         OTL_TM_UV_BIT    = 0;
	localparam int         OTL_TM_FLT_BIT   = 1;
	localparam int         OTL_TM_ARS_BIT   = 2;
	localparam logic [2:0] OTL_TM_RESET     = 3'h2;
	// Polarity field positions; expansion bits follow
	localparam int         OTL_POL_RLY1_BIT = 0;
	localparam int         OTL_POL_OC_BIT   = 1;
	localparam int         OTL_POL_RLY2_BIT = 2;
	localparam logic [5:0] OTL_POL_RESET    = 6'h00;
	// Delay reset (0.00 s) and tick timing
	localparam logic [15:0] OTL_DLY_RESET   = 16'h0000;
	localparam int         OTL_CLK_HZ       = 25000000;
	localparam int         OTL_TICK_MS      = 10;
	localparam int         OTL_TICK_CYC     = OTL_CLK_HZ / 1000 * OTL_TICK_MS;
	// Encoder option mode
	localparam logic [1:0] OTL_ENC_FEEDBACK = 2'h1;
	typedef enum logic [1:0] {OTL_OFF, OTL_WAIT_ON, OTL_ON, OTL_WAIT_OFF} otl_dstate_e;
endpackage

//--- verilog/otl_tick.sv
// Hundredth-of-second tick generator
module otl_tick import otl_pkg::*; #(
	parameter int TICK_CYC = OTL_TICK_CYC
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	output logic      tick
);
	initial begin
		if (TICK_CYC < 1 || TICK_CYC > 1048575) begin
			$error("otl_tick: TICK_CYC out of range");
		end
	end

	logic [19:0] cnt_reg;
	logic [19:0] cnt_next;
	logic        tick_reg;
	logic        tick_next;

	always_comb begin
		cnt_next  = cnt_reg;
		// Held while disabled so a frozen clock freezes the tick too
		tick_next = tick_reg;
		if (ce) begin
			tick_next = 1'b0;
			if (cnt_reg == 20'(TICK_CYC - 1)) begin
				cnt_next  = 20'h00000;
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 20'h00001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg  <= 20'h00000;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule

//--- verilog/otl_delay.sv
// On/off delay stage for one output
module otl_delay import otl_pkg::*; (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        tick,
	input  wire logic        func_in,
	input  wire logic [15:0] on_dly,
	input  wire logic [15:0] off_dly,
	output logic             state_out
);
	otl_dstate_e st_reg;
	otl_dstate_e st_next;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;

	always_comb begin
		st_next  = st_reg;
		cnt_next = cnt_reg;
		if (ce) begin
			case (st_reg)
				OTL_OFF: begin
					if (func_in) begin
						st_next  = (on_dly == 16'h0000) ? OTL_ON : OTL_WAIT_ON;
						cnt_next = 16'h0000;
					end
				end
				OTL_WAIT_ON: begin
					if (!func_in) begin
						st_next = OTL_OFF;
					end else if (tick) begin
						if (cnt_reg + 16'h0001 >= on_dly) begin
							st_next = OTL_ON;
						end
						cnt_next = cnt_reg + 16'h0001;
					end
				end
				OTL_ON: begin
					if (!func_in) begin
						st_next  = (off_dly == 16'h0000) ? OTL_OFF : OTL_WAIT_OFF;
						cnt_next = 16'h0000;
					end
				end
				OTL_WAIT_OFF: begin
					if (func_in) begin
						st_next = OTL_ON;
					end else if (tick) begin
						if (cnt_reg + 16'h0001 >= off_dly) begin
							st_next = OTL_OFF;
						end
						cnt_next = cnt_reg + 16'h0001;
					end
				end
				default: st_next = OTL_OFF;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg  <= OTL_OFF;
			cnt_reg <= 16'h0000;
		end else begin
			st_reg  <= st_next;
			cnt_reg <= cnt_next;
		end
	end

	assign state_out = (st_reg == OTL_ON) || (st_reg == OTL_WAIT_OFF);
endmodule

//--- verilog/otl_top.sv
// Output terminal stage: function select, trip mask, delays, polarity
// Function
// - Mask bit one set: undervoltage trip drives trip function.
// - Mask bit two set: any other fault trip drives trip function.
// - Mask bit three set: failed automatic restart drives trip function.
// - Three-bit trip mask, reset value 010, bit one rightmost.
// - Outputs selecting trip code switch on for masked trip.
// - Trip outputs turn on after trip on-delay, default zero.
// - Trip outputs turn off after trip off-delay once cleared.
// - Non-trip outputs wait general on-delay before switching on.
// - Non-trip outputs wait general off-delay before switching off.
// - General delays cover all outputs except trip-assigned ones.
// - Polarity 0 normally open, 1 normally closed.
// - Polarity resets to zeros; bit0 first relay, bit1 open collector.
// - Expansion module adds three polarity bits for its outputs.
// - Readable bitmap shows present on/off state of each output.
// - Encoder direction warning in feedback mode on direction mismatch.
// - Energy buffer function asserts while buffering after power loss.
// - Fire mode function asserts only when enabled and running.
// - Extended run asserts on run or voltage, also during DC braking.
module otl_top import otl_pkg::*; #(
	parameter int TICK_CYC = OTL_TICK_CYC,
	parameter int NEXP     = 3
) (
	input  wire logic              CLK_SYS,
	input  wire logic              SYS_RST,
	input  wire logic              CE,
	// Configuration
	input  wire logic [2:0]        TRIP_MASK,
	input  wire logic              CFG_LOAD,
	input  wire logic [7:0]        SEL_FIRST_RELAY,
	input  wire logic [7:0]        SEL_SECOND_RELAY,
	input  wire logic [7:0]        SEL_OPEN_COLLECTOR,
	input  wire logic [8*NEXP-1:0] SEL_EXP,
	input  wire logic              EXP_PRESENT,
	input  wire logic [5:0]        POLARITY,
	input  wire logic [15:0]       TRIP_ON_DLY,
	input  wire logic [15:0]       TRIP_OFF_DLY,
	input  wire logic [15:0]       DO_ON_DLY,
	input  wire logic [15:0]       DO_OFF_DLY,
	input  wire logic [1:0]        ENCODER_OPTION_SELECT,
	input  wire logic              OVERRIDE_ENABLE_SETTING,
	// Drive status
	input  wire logic              TRIP_UNDERVOLTAGE,
	input  wire logic              TRIP_OTHER,
	input  wire logic              RESTART_FAILED,
	input  wire logic              ENC_DIR_MISMATCH,
	input  wire logic              ENERGY_BUFFER_ACTIVE,
	input  wire logic              FIRE_MODE_RUNNING,
	input  wire logic              RUN_CMD,
	input  wire logic              VOLTAGE_OUT,
	input  wire logic              DC_BRAKING,
	input  wire logic              FREQUENCY_DETECT_ONE,
	// Outputs
	output logic                   FIRST_RELAY,
	output logic                   SECOND_RELAY,
	output logic                   OPEN_COLLECTOR_OUTPUT,
	output logic [NEXP-1:0]        EXP_OUT,
	output logic [5:0]             DO_STATE
);
	localparam int NOUT = 3 + NEXP;

	initial begin
		if (NEXP != 3) begin
			$error("otl_top: NEXP must be 3 to fit the polarity field");
		end
	end

	// Config registers
	logic [2:0]  mask_reg;
	logic [2:0]  mask_next;
	logic [5:0]  pol_reg;
	logic [5:0]  pol_next;
	logic [15:0] ton_reg;
	logic [15:0] ton_next;
	logic [15:0] toff_reg;
	logic [15:0] toff_next;
	logic [15:0] gon_reg;
	logic [15:0] gon_next;
	logic [15:0] goff_reg;
	logic [15:0] goff_next;

	always_comb begin
		mask_next = mask_reg;
		pol_next  = pol_reg;
		ton_next  = ton_reg;
		toff_next = toff_reg;
		gon_next  = gon_reg;
		goff_next = goff_reg;
		if (CE && CFG_LOAD) begin
			mask_next = TRIP_MASK;
			pol_next  = EXP_PRESENT ? POLARITY : {3'h0, POLARITY[2:0]};
			ton_next  = TRIP_ON_DLY;
			toff_next = TRIP_OFF_DLY;
			gon_next  = DO_ON_DLY;
			goff_next = DO_OFF_DLY;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			mask_reg <= OTL_TM_RESET;
			pol_reg  <= OTL_POL_RESET;
			ton_reg  <= OTL_DLY_RESET;
			toff_reg <= OTL_DLY_RESET;
			gon_reg  <= OTL_DLY_RESET;
			goff_reg <= OTL_DLY_RESET;
		end else begin
			mask_reg <= mask_next;
			pol_reg  <= pol_next;
			ton_reg  <= ton_next;
			toff_reg <= toff_next;
			gon_reg  <= gon_next;
			goff_reg <= goff_next;
		end
	end

	// Status functions
	logic trip_fn;
	logic enc_fn;
	logic fire_fn;
	logic run_fn;
	logic xrun_fn;

	always_comb begin
		trip_fn = (mask_reg[OTL_TM_UV_BIT] && TRIP_UNDERVOLTAGE)
			|| (mask_reg[OTL_TM_FLT_BIT] && TRIP_OTHER)
			|| (mask_reg[OTL_TM_ARS_BIT] && RESTART_FAILED);
		enc_fn  = (ENCODER_OPTION_SELECT == OTL_ENC_FEEDBACK) && ENC_DIR_MISMATCH;
		fire_fn = OVERRIDE_ENABLE_SETTING && FIRE_MODE_RUNNING;
		// Plain run drops during DC braking
		run_fn  = (RUN_CMD || VOLTAGE_OUT) && !DC_BRAKING;
		xrun_fn = RUN_CMD || VOLTAGE_OUT || DC_BRAKING;
	end

	// Selected function for one output; unknown codes stay off
	function automatic logic fn_of(input logic [7:0] sel, input logic tf, input logic ef,
		input logic kf, input logic ff, input logic rf, input logic r2, input logic fd);
		logic v;
		v = 1'b0;
		case (sel)
			OTL_FN_FDT:     v = fd;
			OTL_FN_RUN:     v = rf;
			OTL_FN_TRIP:    v = tf;
			OTL_FN_ENC_DIR: v = ef;
			OTL_FN_EBUF:    v = kf;
			OTL_FN_FIRE:    v = ff;
			OTL_FN_XRUN:    v = r2;
			default:        v = 1'b0;
		endcase
		return v;
	endfunction

	logic [8*NOUT-1:0] sel_all;
	logic [NOUT-1:0]   fn_vec;
	logic [NOUT-1:0]   on_vec;
	logic [NOUT-1:0]   out_next;
	logic [NOUT-1:0]   out_reg;
	logic              tick;

	assign sel_all = {SEL_EXP, SEL_SECOND_RELAY, SEL_OPEN_COLLECTOR, SEL_FIRST_RELAY};

	otl_tick #(
		.TICK_CYC (TICK_CYC)
	) u_tick (
		.clk  (CLK_SYS),
		.rst  (SYS_RST),
		.ce   (CE),
		.tick (tick)
	);

	for (genvar i = 0; i < NOUT; i++) begin : g_out
		logic        is_trip;
		logic [15:0] d_on;
		logic [15:0] d_off;
		assign is_trip = (sel_all[8*i +: 8] == OTL_FN_TRIP);
		assign fn_vec[i] = fn_of(sel_all[8*i +: 8], trip_fn, enc_fn, ENERGY_BUFFER_ACTIVE,
			fire_fn, run_fn, xrun_fn, FREQUENCY_DETECT_ONE);
		// general on, general off, not for trip
		assign d_on  = is_trip ? ton_reg : gon_reg;
		assign d_off = is_trip ? toff_reg : goff_reg;
		otl_delay u_dly (
			.clk       (CLK_SYS),
			.rst       (SYS_RST),
			.ce        (CE),
			.tick      (tick),
			.func_in   (fn_vec[i]),
			.on_dly    (d_on),
			.off_dly   (d_off),
			.state_out (on_vec[i])
		);
	end

	always_comb begin
		out_next = out_reg;
		if (CE) begin
			out_next = on_vec ^ pol_reg[NOUT-1:0];
			if (!EXP_PRESENT) begin
				out_next[NOUT-1:3] = '0;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			out_reg <= '0;
		end else begin
			out_reg <= out_next;
		end
	end

	// Bit order: first relay, open collector, second relay, expansion
	assign FIRST_RELAY           = out_reg[OTL_POL_RLY1_BIT];
	assign OPEN_COLLECTOR_OUTPUT = out_reg[OTL_POL_OC_BIT];
	assign SECOND_RELAY          = out_reg[OTL_POL_RLY2_BIT];
	assign EXP_OUT               = out_reg[NOUT-1:3];
	assign DO_STATE              = out_reg;
endmodule

//--- test/otl_monitor.sv
// Port-level checker for the output terminal stage
module otl_monitor import otl_pkg::*; #(
	parameter int NEXP = 3
) (
	input wire logic            CLK_SYS,
	input wire logic            SYS_RST,
	input wire logic            CE,
	input wire logic            CFG_LOAD,
	input wire logic [2:0]      TRIP_MASK,
	input wire logic [5:0]      POLARITY,
	input wire logic [15:0]     TRIP_ON_DLY,
	input wire logic [15:0]     TRIP_OFF_DLY,
	input wire logic [15:0]     DO_ON_DLY,
	input wire logic [15:0]     DO_OFF_DLY,
	input wire logic [7:0]      SEL_FIRST_RELAY,
	input wire logic [7:0]      SEL_SECOND_RELAY,
	input wire logic [7:0]      SEL_OPEN_COLLECTOR,
	input wire logic            EXP_PRESENT,
	input wire logic            TRIP_UNDERVOLTAGE,
	input wire logic            TRIP_OTHER,
	input wire logic            RESTART_FAILED,
	input wire logic            ENERGY_BUFFER_ACTIVE,
	input wire logic            RUN_CMD,
	input wire logic            VOLTAGE_OUT,
	input wire logic            DC_BRAKING,
	input wire logic            FIRST_RELAY,
	input wire logic            SECOND_RELAY,
	input wire logic            OPEN_COLLECTOR_OUTPUT,
	input wire logic [NEXP-1:0] EXP_OUT,
	input wire logic [5:0]      DO_STATE
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] m_reg, m_next, p_reg, p_next;
	logic       z_reg, z_next, q, trip_fn;
	// Shadow of loaded config; trip, buffer and run checks only run with all delays zero
	always_comb begin
		m_next = m_reg;
		p_next = p_reg;
		z_next = z_reg;
		if (SYS_RST) begin
			m_next = OTL_TM_RESET;
			p_next = 3'h0;
			z_next = 1'b1;
		end else if (CE && CFG_LOAD) begin
			m_next = TRIP_MASK;
			p_next = POLARITY[2:0];
			z_next = ~|{TRIP_ON_DLY, TRIP_OFF_DLY, DO_ON_DLY, DO_OFF_DLY};
		end
	end
	always_ff @(posedge CLK_SYS) begin
		m_reg <= m_next;
		p_reg <= p_next;
		z_reg <= z_next;
	end
	assign q = CE && !CFG_LOAD && z_reg;
	assign trip_fn = |(m_reg & {RESTART_FAILED, TRIP_OTHER, TRIP_UNDERVOLTAGE});
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	chk_reset_clears_outs: assert property ($past(SYS_RST) |-> DO_STATE == 6'h00)
		else $error("outputs not clear after reset");
	chk_state_bit_map: assert property (DO_STATE == {EXP_OUT, SECOND_RELAY, OPEN_COLLECTOR_OUTPUT, FIRST_RELAY})
		else $error("state bitmap differs from outputs");
	chk_trip_out_on: assert property (
		(q && SEL_FIRST_RELAY == OTL_FN_TRIP && trip_fn)[*2]
		|=> FIRST_RELAY != p_reg[0])
		else $error("trip relay not on");
	chk_trip_mask_off: assert property (
		(q && SEL_FIRST_RELAY == OTL_FN_TRIP && !trip_fn)[*2]
		|=> FIRST_RELAY == p_reg[0])
		else $error("masked trip drove relay");
	chk_buffer_out_on: assert property (
		(q && SEL_OPEN_COLLECTOR == OTL_FN_EBUF && ENERGY_BUFFER_ACTIVE)[*2]
		|=> OPEN_COLLECTOR_OUTPUT != p_reg[1])
		else $error("buffer output not on");
	chk_xrun_on: assert property (
		(q && SEL_SECOND_RELAY == OTL_FN_XRUN && (RUN_CMD || VOLTAGE_OUT))[*2]
		|=> SECOND_RELAY != p_reg[2])
		else $error("extended run not on");
	chk_run_brake_off: assert property (
		(q && SEL_SECOND_RELAY == OTL_FN_RUN && DC_BRAKING)[*2]
		|=> SECOND_RELAY == p_reg[2])
		else $error("plain run on while braking");
	chk_exp_absent_off: assert property ((!EXP_PRESENT)[*2] |-> EXP_OUT == '0)
		else $error("expansion output without module");
endmodule
bind otl_top otl_monitor #(.NEXP(NEXP)) u_monitor (.*);

//--- test/otl_field_model.sv
// Field wiring seen by the drive's output terminals
module otl_field_model (
	input  wire logic first_relay,
	input  wire logic second_relay,
	input  wire logic open_collector,
	output logic      oc_line,
	output logic      rly1_shut,
	output logic      rly2_shut
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pull-up holds the line high while the transistor is off
	assign oc_line = !open_collector;
	assign rly1_shut = first_relay;
	assign rly2_shut = second_relay;
endmodule

//--- test/test_otl_top.sv
// Self-checking bench for the output terminal stage
module test_otl_top import otl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLK_SYS = 0, SYS_RST = 1, CE = 1, CFG_LOAD = 0, EXP_PRESENT = 0;
	logic [2:0]  TRIP_MASK = 3'h2;
	logic [7:0]  SEL_FIRST_RELAY = 8'h00, SEL_SECOND_RELAY = 8'h00, SEL_OPEN_COLLECTOR = 8'h00;
	logic [23:0] SEL_EXP = 24'h000000;
	logic [5:0]  POLARITY = 6'h00, DO_STATE;
	logic [15:0] TRIP_ON_DLY = 16'h0, TRIP_OFF_DLY = 16'h0, DO_ON_DLY = 16'h0, DO_OFF_DLY = 16'h0;
	logic [1:0]  ENCODER_OPTION_SELECT = 2'h0;
	logic        OVERRIDE_ENABLE_SETTING = 0, TRIP_UNDERVOLTAGE = 0, TRIP_OTHER = 0;
	logic        RESTART_FAILED = 0, ENC_DIR_MISMATCH = 0, ENERGY_BUFFER_ACTIVE = 0;
	logic        FIRE_MODE_RUNNING = 0, RUN_CMD = 0, VOLTAGE_OUT = 0, DC_BRAKING = 0;
	logic        FREQUENCY_DETECT_ONE = 0, FIRST_RELAY, SECOND_RELAY, OPEN_COLLECTOR_OUTPUT;
	logic [2:0]  EXP_OUT;
	logic        oc_line, rly1_shut, rly2_shut;
	int          num_errors = 0, cmp_count = 0;
	always #20 CLK_SYS = ~CLK_SYS;
	// Short tick keeps delay scenarios to tens of cycles
	otl_top #(.TICK_CYC(4)) u_dut (.*);
	otl_field_model u_field (.first_relay(FIRST_RELAY), .second_relay(SECOND_RELAY),
		.open_collector(OPEN_COLLECTOR_OUTPUT), .oc_line(oc_line), .rly1_shut(rly1_shut),
		.rly2_shut(rly2_shut));
	task automatic step(input int n);
		repeat (n) @(posedge CLK_SYS);
		#2;
	endtask
	task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cfg(input logic [2:0] m, input logic [5:0] p,
		input logic [15:0] ton, toff, don, doff);
		TRIP_MASK = m;
		POLARITY = p;
		{TRIP_ON_DLY, TRIP_OFF_DLY, DO_ON_DLY, DO_OFF_DLY} = {ton, toff, don, doff};
		CFG_LOAD = 1;
		step(1);
		CFG_LOAD = 0;
		step(3);
	endtask
	task automatic fn(input logic [7:0] code, input logic [8:0] st, input logic e);
		SEL_OPEN_COLLECTOR = code;
		SEL_SECOND_RELAY = code;
		{ENCODER_OPTION_SELECT, ENC_DIR_MISMATCH, ENERGY_BUFFER_ACTIVE, FIRE_MODE_RUNNING,
			OVERRIDE_ENABLE_SETTING, RUN_CMD, VOLTAGE_OUT, DC_BRAKING} = st;
		cfg(TRIP_MASK, POLARITY, 16'h0, 16'h0, 16'h0, 16'h0);
		chk("function on oc and relay2", {4'h0, e, e}, {4'h0, DO_STATE[2:1]});
	endtask
	task automatic give_verdict;
		$display("comparisons %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#(40 * 3000);
		num_errors++;
		give_verdict;
	end
	initial begin
		step(4);
		SYS_RST = 0;
		chk("state after reset", 6'h00, DO_STATE);
		SEL_FIRST_RELAY = OTL_FN_TRIP;
		TRIP_UNDERVOLTAGE = 1;
		step(3);
		chk("undervoltage default mask", 6'h00, {5'h0, FIRST_RELAY});
		TRIP_OTHER = 1;
		step(3);
		chk("trip relay state", 6'h01, DO_STATE);
		chk("relay contact", 6'h01, {5'h0, rly1_shut});
		for (int i = 0; i < 3; i++) begin
			cfg(3'h1 << i, 6'h00, 16'h0, 16'h0, 16'h0, 16'h0);
			for (int j = 0; j < 3; j++) begin
				{RESTART_FAILED, TRIP_OTHER, TRIP_UNDERVOLTAGE} = 3'h1 << j;
				step(3);
				chk("trip source", {5'h0, i == j}, {5'h0, FIRST_RELAY});
			end
		end
		{RESTART_FAILED, TRIP_OTHER, TRIP_UNDERVOLTAGE} = 3'h0;
		SEL_FIRST_RELAY = 8'h00;
		fn(OTL_FN_ENC_DIR, 9'h0c0, 1'b1);
		fn(OTL_FN_ENC_DIR, 9'h040, 1'b0);
		fn(OTL_FN_EBUF, 9'h020, 1'b1);
		fn(OTL_FN_FIRE, 9'h010, 1'b0);
		fn(OTL_FN_FIRE, 9'h018, 1'b1);
		fn(OTL_FN_XRUN, 9'h003, 1'b1);
		fn(OTL_FN_RUN, 9'h003, 1'b0);
		fn(OTL_FN_RUN, 9'h002, 1'b1);
		fn(OTL_FN_XRUN, 9'h000, 1'b0);
		cfg(TRIP_MASK, 6'h3f, 16'h0, 16'h0, 16'h0, 16'h0);
		chk("polarity without expansion", 6'h07, DO_STATE);
		chk("oc line pulled low", 6'h00, {5'h0, oc_line});
		EXP_PRESENT = 1;
		cfg(TRIP_MASK, 6'h3f, 16'h0, 16'h0, 16'h0, 16'h0);
		chk("polarity with expansion", 6'h3f, DO_STATE);
		cfg(3'h2, 6'h00, 16'h2, 16'h3, 16'h8, 16'h1);
		SEL_SECOND_RELAY = OTL_FN_EBUF;
		ENERGY_BUFFER_ACTIVE = 1;
		step(4);
		ENERGY_BUFFER_ACTIVE = 0;
		step(40);
		chk("short pulse dropped", 6'h00, {5'h0, SECOND_RELAY});
		ENERGY_BUFFER_ACTIVE = 1;
		step(24);
		chk("general on wait", 6'h00, {5'h0, SECOND_RELAY});
		step(12);
		chk("general on done", 6'h01, {5'h0, SECOND_RELAY});
		chk("relay2 contact", 6'h01, {5'h0, rly2_shut});
		// Disabled clock must hold the output through the drop
		CE = 0;
		ENERGY_BUFFER_ACTIVE = 0;
		step(10);
		chk("frozen while disabled", 6'h01, {5'h0, SECOND_RELAY});
		CE = 1;
		step(7);
		chk("general off done", 6'h00, {5'h0, SECOND_RELAY});
		SEL_FIRST_RELAY = OTL_FN_TRIP;
		TRIP_OTHER = 1;
		step(3);
		chk("trip on wait", 6'h00, {5'h0, FIRST_RELAY});
		step(9);
		chk("trip on own delay", 6'h01, {5'h0, FIRST_RELAY});
		TRIP_OTHER = 0;
		step(8);
		chk("trip off wait", 6'h01, {5'h0, FIRST_RELAY});
		step(8);
		chk("trip off done", 6'h00, {5'h0, FIRST_RELAY});
		give_verdict;
	end
endmodule
